// [inc/mcs_pkg.sv]
// constants, types and register layout for the measurement conversion sequencer
package mcs_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_SETUP = 8'h00;
   localparam logic [7:0] ADDR_CTIME = 8'h04;
   localparam logic [7:0] ADDR_TTIME = 8'h08;
   localparam logic [7:0] ADDR_TCOEF = 8'h0c;
   localparam logic [7:0] ADDR_CURR = 8'h10;
   localparam logic [7:0] ADDR_VBUS = 8'h14;
   localparam logic [7:0] ADDR_TEMP = 8'h18;
   localparam logic [7:0] ADDR_POWER = 8'h1c;
   localparam logic [7:0] ADDR_ENERGY = 8'h20;
   localparam logic [7:0] ADDR_CHARGE = 8'h24;
   localparam logic [7:0] ADDR_DIAG = 8'h28;
   // field positions
   localparam int SETUP_MODE_LSB = 0;
   localparam int SETUP_AVG_LSB = 3;
   localparam int CTIME_SHUNT_LSB = 0;
   localparam int CTIME_BUS_LSB = 16;
   localparam int TTIME_TEMP_LSB = 0;
   localparam int TTIME_DLY_LSB = 16;
   localparam int DIAG_DONE_BIT = 0;
   localparam int DIAG_ALERT_EN_BIT = 1;
   localparam int DIAG_ACC_VALID_BIT = 2;
   localparam int DIAG_BUSY_BIT = 3;
   // reset values
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [3:0] AVG_RST = 4'h0;
   localparam logic [12:0] CT_RST = 13'h041c;
   localparam logic [7:0] DLY_RST = 8'h00;
   localparam logic [15:0] TCOEF_RST = 16'h0000;
   // mode encoding: bit 2 continuous, bits 1:0 channel selection
   localparam logic [1:0] SEL_OFF = 2'h0;
   localparam logic [1:0] SEL_ALL = 2'h1;
   localparam logic [1:0] SEL_CUR = 2'h2;
   localparam logic [1:0] SEL_BUS = 2'h3;
   localparam logic [3:0] AVG_EXP_MAX = 4'ha;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1000;
   localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [12:0] CT_MIN_US = 13'd50;
   localparam logic [12:0] CT_MAX_US = 13'd4120;
   localparam logic [18:0] DLY_STEP_US = 19'd2000;
   localparam int TCOMP_SHIFT = 12;
   // widths
   localparam int SMP_W = 20;
   localparam int ACC_W = 30;

   typedef enum logic [1:0] {
      CH_TEMP = 2'b00,
      CH_SHUNT = 2'b01,
      CH_BUS = 2'b10
   } chan_type;

   typedef struct packed {
      logic run;
      chan_type chan;
      logic flt_clr;
      logic [12:0] ct_us;
   } adc_ctl_type;
endpackage

// [core/mcs_sequencer.sv]
// conversion sequencer, averaging and power/energy/charge engine
//
// Behaviour
// R1 - power uses latest current result and newest bus voltage after bus conversion
// R2 - averaging of one writes each result straight to its output register
// R3 - averaging adds samples per quantity, then loads averages and power together; power loads one cycle after the averages
// R4 - energy and charge accumulate once per cycle, never averaged; the code accumulates them in continuous mode only
// R5 - calculations run beside conversion and never lengthen the sequence
// R6 - temperature converts before every current and compensates that current
// R7 - mode selects current only, bus voltage only, or all channels
// R8 - each input has its own conversion time, 50 us to 4.12 ms
// R9 - current is ready after temperature plus shunt conversion times
// R10 - enabled inputs convert one after another through one converter
// R11 - output registers hold until a full new result; reads never disturb
// R12 - continuous mode repeats the whole sequence forever, updating each time
// R13 - triggered mode runs one sequence then shuts down until mode rewritten
// R14 - any mode write aborts the running sequence and restarts per new mode
// R15 - done flag sets only after all conversions and averaging complete
// R16 - done flag clears on diagnostic read or non-shutdown setup write
// R17 - energy and charge are marked invalid in triggered mode
// R18 - host picks continuous mode when accumulated energy must be trusted
// R19 - start delay 0 to 510 ms in 2 ms steps, zero by default
// R20 - filter follows selected conversion time and settles within one conversion
// R21 - averaging one to 1024 conversions, same count for every input
// R22 - registers stay accessible in shutdown; only a conversion mode leaves it
// R23 - done flag records completions regardless of alert enable
// R24 - done flag stays set until a clearing condition occurs
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module mcs_sequencer #(
   parameter int unsigned US_CYCLES = mcs_pkg::CYC_PER_US
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata_q,
   input wire logic [mcs_pkg::SMP_W-1:0] adc_sample,
   output mcs_pkg::adc_ctl_type adc_ctl_q,
   output logic shutdown_q,
   output logic done_q,
   output logic alert_en_q
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DELAY = 3'b001,
      ST_TEMP = 3'b010,
      ST_SHUNT = 3'b011,
      ST_BUS = 3'b100
   } mcs_state_type;

   localparam logic [15:0] PRE_LAST = 16'(US_CYCLES - 1);

   // channel of a conversion state
   function automatic mcs_pkg::chan_type st2ch(input mcs_state_type s);
      st2ch = (s == ST_SHUNT) ? mcs_pkg::CH_SHUNT :
              (s == ST_BUS) ? mcs_pkg::CH_BUS : mcs_pkg::CH_TEMP;
   endfunction

   // limit conversion time to the supported range
   function automatic logic [12:0] ct_clamp(input logic [12:0] v);
      ct_clamp = (v < mcs_pkg::CT_MIN_US) ? mcs_pkg::CT_MIN_US :
                 (v > mcs_pkg::CT_MAX_US) ? mcs_pkg::CT_MAX_US : v;
   endfunction

   function automatic logic is_conv(input mcs_state_type s);
      is_conv = (s == ST_TEMP) || (s == ST_SHUNT) || (s == ST_BUS);
   endfunction

   function automatic logic [mcs_pkg::ACC_W-1:0] sext(input logic [mcs_pkg::SMP_W-1:0] v);
      sext = {{(mcs_pkg::ACC_W - mcs_pkg::SMP_W){v[mcs_pkg::SMP_W-1]}}, v};
   endfunction

   mcs_state_type st_q, st_d;
   logic [2:0] mode_q;
   logic [3:0] avg_q;
   logic [12:0] ct_s_q, ct_b_q, ct_t_q;
   logic [7:0] dly_q;
   logic signed [15:0] tcoef_q;
   logic [18:0] tmr_q, ld_val;
   logic [15:0] pre_q;
   logic ld;
   logic [10:0] rnd_q;
   logic signed [mcs_pkg::SMP_W-1:0] last_temp_q;
   logic signed [mcs_pkg::ACC_W-1:0] acc_q [0:2];
   logic signed [mcs_pkg::ACC_W-1:0] sum_q [0:2];
   logic signed [mcs_pkg::ACC_W-1:0] acc_sum_w [0:2];
   logic [mcs_pkg::SMP_W-1:0] res_q [0:2];
   logic [31:0] power_q, energy_q, charge_q;
   logic p1_q, p2_q, p3_q;
   logic valid_q;

   // bus decode
   wire setup_wr = wr_en && (addr == mcs_pkg::ADDR_SETUP);
   wire ctime_wr = wr_en && (addr == mcs_pkg::ADDR_CTIME);
   wire ttime_wr = wr_en && (addr == mcs_pkg::ADDR_TTIME);
   wire tcoef_wr = wr_en && (addr == mcs_pkg::ADDR_TCOEF);
   wire diag_wr = wr_en && (addr == mcs_pkg::ADDR_DIAG);
   wire diag_rd = rd_en && (addr == mcs_pkg::ADDR_DIAG);
   wire [2:0] wmode = wdata[mcs_pkg::SETUP_MODE_LSB +: 3];

   // channel enables from the mode field
   wire [1:0] sel = mode_q[1:0];
   wire cur_en = (sel == mcs_pkg::SEL_ALL) || (sel == mcs_pkg::SEL_CUR); // R7
   wire bus_en = (sel == mcs_pkg::SEL_ALL) || (sel == mcs_pkg::SEL_BUS); // R7
   wire cont = mode_q[2];
   wire [3:0] avg_exp = (avg_q > mcs_pkg::AVG_EXP_MAX) ? mcs_pkg::AVG_EXP_MAX : avg_q; // R21
   wire [10:0] rnd_last = (11'h001 << avg_exp) - 11'h001; // R21
   wire immediate = (avg_exp == 4'h0);

   // per-input conversion times
   wire [12:0] ct_t = ct_clamp(ct_t_q); // R8
   wire [12:0] ct_s = ct_clamp(ct_s_q); // R8
   wire [12:0] ct_b = ct_clamp(ct_b_q); // R8
   wire [12:0] ct_first = cur_en ? ct_t : ct_b;
   wire [18:0] dly_us = 19'(dly_q) * mcs_pkg::DLY_STEP_US; // R19

   // sequence timing
   wire us_tick = (pre_q == PRE_LAST);
   wire tmr_zero = (tmr_q == 19'h00000);
   wire conv_end = is_conv(st_q) && tmr_zero;
   wire last_ch = (st_q == ST_BUS) || ((st_q == ST_SHUNT) && !bus_en);
   wire round_end = conv_end && last_ch;
   wire final_round = round_end && (rnd_q == rnd_last); // R3 R15
   wire mcs_state_type first_st = cur_en ? ST_TEMP : ST_BUS; // R6
   wire mcs_pkg::chan_type cur_ch = st2ch(st_q);

   // temperature compensation of the shunt sample
   wire signed [mcs_pkg::SMP_W-1:0] smp = adc_sample;
   wire signed [35:0] tprod = last_temp_q * tcoef_q;
   wire signed [mcs_pkg::SMP_W-1:0] tcorr = tprod[mcs_pkg::TCOMP_SHIFT +: mcs_pkg::SMP_W];
   wire signed [mcs_pkg::SMP_W-1:0] comp = smp - tcorr; // R6
   wire [mcs_pkg::SMP_W-1:0] in_w = (cur_ch == mcs_pkg::CH_SHUNT) ? comp : smp;

   // power from stored current and voltage
   wire signed [39:0] pprod = $signed(res_q[1]) * $signed(res_q[2]); // R1
   wire [31:0] cur32 = {{(32 - mcs_pkg::SMP_W){res_q[1][mcs_pkg::SMP_W-1]}}, res_q[1]};

   // next state and timer loads
   always_comb begin
      st_d = st_q;
      ld = 1'b0;
      ld_val = 19'h00000;
      if (setup_wr) begin
         if (wmode[1:0] == mcs_pkg::SEL_OFF) begin
            st_d = ST_IDLE; // R14
         end else begin
            st_d = ST_DELAY; // R14 R19
            ld = 1'b1;
            ld_val = dly_us;
         end
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               st_d = ST_IDLE; // R22
            end
            ST_DELAY: begin
               if (tmr_zero) begin
                  st_d = first_st;
                  ld = 1'b1;
                  ld_val = {6'h00, ct_first};
               end
            end
            ST_TEMP: begin
               if (tmr_zero) begin
                  st_d = ST_SHUNT; // R9
                  ld = 1'b1;
                  ld_val = {6'h00, ct_s};
               end
            end
            ST_SHUNT, ST_BUS: begin
               if (tmr_zero) begin
                  if ((st_q == ST_SHUNT) && bus_en) begin
                     st_d = ST_BUS; // R10
                     ld = 1'b1;
                     ld_val = {6'h00, ct_b};
                  end else if (final_round && !cont) begin
                     st_d = ST_IDLE; // R13
                  end else begin
                     st_d = first_st; // R12
                     ld = 1'b1;
                     ld_val = {6'h00, ct_first};
                  end
               end
            end
            default: begin
               st_d = ST_IDLE;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // microsecond timer, restarted at every state load
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tmr_q <= 19'h00000;
         pre_q <= 16'h0000;
      end else if (ld) begin
         tmr_q <= ld_val;
         pre_q <= 16'h0000;
      end else if (us_tick) begin
         pre_q <= 16'h0000;
         if (!tmr_zero) begin
            tmr_q <= tmr_q - 19'h00001;
         end
      end else begin
         pre_q <= pre_q + 16'h0001;
      end
   end

   // converter control toward the analog side and filter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         adc_ctl_q <= '0;
         shutdown_q <= 1'b1;
      end else begin
         adc_ctl_q.run <= is_conv(st_d); // R10
         adc_ctl_q.chan <= st2ch(st_d);
         adc_ctl_q.flt_clr <= ld && is_conv(st_d); // R20
         adc_ctl_q.ct_us <= (st2ch(st_d) == mcs_pkg::CH_SHUNT) ? ct_s : // R20
                            (st2ch(st_d) == mcs_pkg::CH_BUS) ? ct_b : ct_t;
         shutdown_q <= (st_d == ST_IDLE); // R13
      end
   end

   // averaging round counter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rnd_q <= 11'h000;
      end else if (setup_wr || final_round) begin
         rnd_q <= 11'h000;
      end else if (round_end) begin
         rnd_q <= rnd_q + 11'h001; // R21
      end
   end

   // temperature seen just before the current conversion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_temp_q <= '0;
      end else if (conv_end && (cur_ch == mcs_pkg::CH_TEMP)) begin
         last_temp_q <= smp; // R6
      end
   end

   // per-quantity accumulators and results
   generate
      for (genvar c = 0; c < 3; c++) begin : g_ch
         wire hit = conv_end && (cur_ch == mcs_pkg::chan_type'(c));
         wire signed [mcs_pkg::ACC_W-1:0] shifted = sum_q[c] >>> avg_exp;
         wire ch_en = (c == 2) ? bus_en : cur_en;
         assign acc_sum_w[c] = acc_q[c] + (hit ? sext(in_w) : '0);

         // accumulator adds each sample until the count is reached
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               acc_q[c] <= '0;
               sum_q[c] <= '0;
            end else if (setup_wr) begin
               acc_q[c] <= '0; // R14
            end else if (final_round) begin
               acc_q[c] <= '0;
               sum_q[c] <= acc_sum_w[c]; // R3
            end else if (hit) begin
               acc_q[c] <= acc_sum_w[c]; // R3
            end
         end

         // output register, held until a complete new value
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               res_q[c] <= '0;
            end else if (immediate && hit) begin
               res_q[c] <= in_w; // R2
            end else if (!immediate && p1_q && ch_en) begin
               res_q[c] <= shifted[mcs_pkg::SMP_W-1:0]; // R3 R11
            end
         end
      end
   endgenerate

   // background pipeline: load, power, then accumulate and flag
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         p3_q <= 1'b0;
      end else begin
         p1_q <= final_round && !setup_wr; // R5
         p2_q <= p1_q && !setup_wr;
         p3_q <= p2_q && !setup_wr;
      end
   end

   // power after the newest bus voltage result
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         power_q <= 32'h00000000;
      end else if (p2_q && bus_en) begin
         power_q <= pprod[39:8]; // R1 R3
      end
   end

   // energy and charge, once per completed cycle, continuous only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         energy_q <= 32'h00000000;
         charge_q <= 32'h00000000;
      end else if (p3_q && cont) begin
         if (bus_en) begin
            energy_q <= energy_q + power_q; // R4
         end
         if (cur_en) begin
            charge_q <= charge_q + cur32; // R4
         end
      end
   end

   // accumulators trusted only after a continuous start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         valid_q <= 1'b0;
      end else if (setup_wr && (wmode[1:0] != mcs_pkg::SEL_OFF)) begin
         valid_q <= wmode[2]; // R17
      end
   end

   // done flag: set wins over clear
   wire done_clr = diag_rd || (setup_wr && (wmode[1:0] != mcs_pkg::SEL_OFF)); // R16
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         done_q <= 1'b0;
      end else begin
         done_q <= p3_q || (done_q && !done_clr); // R15 R23 R24
      end
   end

   // configuration registers, writable in any state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= mcs_pkg::MODE_RST;
         avg_q <= mcs_pkg::AVG_RST;
         ct_s_q <= mcs_pkg::CT_RST;
         ct_b_q <= mcs_pkg::CT_RST;
         ct_t_q <= mcs_pkg::CT_RST;
         dly_q <= mcs_pkg::DLY_RST; // R19
         tcoef_q <= mcs_pkg::TCOEF_RST;
         alert_en_q <= 1'b0;
      end else begin
         if (setup_wr) begin
            mode_q <= wmode; // R22
            avg_q <= wdata[mcs_pkg::SETUP_AVG_LSB +: 4];
         end
         if (ctime_wr) begin
            ct_s_q <= wdata[mcs_pkg::CTIME_SHUNT_LSB +: 13];
            ct_b_q <= wdata[mcs_pkg::CTIME_BUS_LSB +: 13];
         end
         if (ttime_wr) begin
            ct_t_q <= wdata[mcs_pkg::TTIME_TEMP_LSB +: 13];
            dly_q <= wdata[mcs_pkg::TTIME_DLY_LSB +: 8];
         end
         if (tcoef_wr) begin
            tcoef_q <= wdata[15:0];
         end
         if (diag_wr) begin
            alert_en_q <= wdata[mcs_pkg::DIAG_ALERT_EN_BIT];
         end
      end
   end

   // read selection
   wire [31:0] diag_w = {28'h0000000, (st_q != ST_IDLE), valid_q, alert_en_q, done_q};
   wire [31:0] rd_w =
      (addr == mcs_pkg::ADDR_SETUP) ? {25'h0000000, avg_q, mode_q} :
      (addr == mcs_pkg::ADDR_CTIME) ? {3'h0, ct_b_q, 3'h0, ct_s_q} :
      (addr == mcs_pkg::ADDR_TTIME) ? {8'h00, dly_q, 3'h0, ct_t_q} :
      (addr == mcs_pkg::ADDR_TCOEF) ? {16'h0000, tcoef_q} :
      (addr == mcs_pkg::ADDR_CURR) ? cur32 :
      (addr == mcs_pkg::ADDR_VBUS) ? {12'h000, res_q[2]} :
      (addr == mcs_pkg::ADDR_TEMP) ? {{12{res_q[0][19]}}, res_q[0]} :
      (addr == mcs_pkg::ADDR_POWER) ? power_q :
      (addr == mcs_pkg::ADDR_ENERGY) ? energy_q :
      (addr == mcs_pkg::ADDR_CHARGE) ? charge_q :
      (addr == mcs_pkg::ADDR_DIAG) ? diag_w : 32'h00000000;

   // read data one cycle after the strobe; no side effect on conversion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h00000000;
      end else if (rd_en) begin
         rdata_q <= rd_w; // R11
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

endmodule

// [bench/mcs_sequencer_sva.sv]
// port checker for the measurement conversion sequencer
`timescale 1ns/1ps
module mcs_sequencer_chk #(
   parameter int unsigned US_CYCLES = 100
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rdata_q,
   input wire logic [mcs_pkg::SMP_W-1:0] adc_sample,
   input wire mcs_pkg::adc_ctl_type adc_ctl_q,
   input wire logic shutdown_q,
   input wire logic done_q,
   input wire logic alert_en_q
);
   mcs_pkg::chan_type last_q;
   logic sd_q, ev1_q, ev2_q;
   // bus decodes
   wire logic setup_wr = wr_en && addr == mcs_pkg::ADDR_SETUP;
   wire logic start_wr = setup_wr && wdata[1:0] != mcs_pkg::SEL_OFF;
   wire logic diag_rd = rd_en && addr == mcs_pkg::ADDR_DIAG;
   // previous start channel; start or stop events two cycles back mark a possible flag set
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_q <= mcs_pkg::CH_BUS;
         sd_q <= 1'b1;
         ev1_q <= 1'b0;
         ev2_q <= 1'b0;
      end else begin
         sd_q <= shutdown_q;
         ev1_q <= adc_ctl_q.flt_clr || (shutdown_q && !sd_q);
         ev2_q <= ev1_q;
         if (adc_ctl_q.flt_clr) begin
            last_q <= adc_ctl_q.chan;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_idle_no_run: assert property (shutdown_q |-> !adc_ctl_q.run)
      else $error("conversion running while shut down");
   a_temp_first: assert property (adc_ctl_q.flt_clr && adc_ctl_q.chan == mcs_pkg::CH_SHUNT |-> last_q == mcs_pkg::CH_TEMP)
      else $error("shunt conversion not preceded by temperature");
   a_chan_steady: assert property (adc_ctl_q.run && !adc_ctl_q.flt_clr |-> $stable(adc_ctl_q.chan))
      else $error("channel changed inside a conversion");
   a_ct_range: assert property (adc_ctl_q.run |-> adc_ctl_q.ct_us >= mcs_pkg::CT_MIN_US && adc_ctl_q.ct_us <= mcs_pkg::CT_MAX_US)
      else $error("conversion time outside range");
   a_clear_pulse: assert property (adc_ctl_q.flt_clr |-> adc_ctl_q.run ##1 !adc_ctl_q.flt_clr)
      else $error("filter clear not a single start pulse");
   a_diag_clear: assert property (diag_rd && !ev2_q |=> !done_q)
      else $error("done flag kept after diagnostic read");
   a_setup_clear: assert property (start_wr && !ev2_q |=> !done_q && !shutdown_q)
      else $error("start write did not clear done or wake");
   a_done_hold: assert property (done_q && !diag_rd && !start_wr |=> done_q)
      else $error("done flag dropped without cause");
   a_mode_abort: assert property (setup_wr |=> !adc_ctl_q.run)
      else $error("mode write did not abort conversion");
   c_done: cover property ($rose(done_q));
   c_cont: cover property (done_q && !shutdown_q && adc_ctl_q.run);
   c_bus: cover property (adc_ctl_q.flt_clr && adc_ctl_q.chan == mcs_pkg::CH_BUS);
endmodule

bind mcs_sequencer mcs_sequencer_chk #(.US_CYCLES(US_CYCLES)) u_chk (.clk(clk), .resetn(resetn),
   .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
   .adc_sample(adc_sample), .adc_ctl_q(adc_ctl_q), .shutdown_q(shutdown_q), .done_q(done_q),
   .alert_en_q(alert_en_q));

// [bench/mcs_adc_model.sv]
// behavioural converter answering the sequencer control struct
`timescale 1ns/1ps
module mcs_adc_model (
   input wire logic clk,
   input wire logic resetn,
   input wire mcs_pkg::adc_ctl_type ctl,
   input wire logic [59:0] vals,
   output logic [19:0] sample,
   output int n_conv [3],
   output int run_len [3]
);
   logic [19:0] last_q;
   int len_q;
   // settled value through the conversion, garbage outside it
   assign sample = ctl.run ? vals[20*int'(ctl.chan) +: 20] : ~last_q;
   // conversion starts and lengths per channel
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_q <= 20'h0;
         len_q <= 0;
         n_conv <= '{0, 0, 0};
         run_len <= '{0, 0, 0};
      end else begin
         last_q <= sample;
         if (ctl.run) begin
            len_q <= ctl.flt_clr ? 1 : len_q + 1;
            run_len[int'(ctl.chan)] <= ctl.flt_clr ? 1 : len_q + 1;
         end
         if (ctl.flt_clr) begin
            n_conv[int'(ctl.chan)] <= n_conv[int'(ctl.chan)] + 1;
         end
      end
   end
endmodule

// [bench/measurement_conversion_sequencer_bench.sv]
// self-checking bench for the measurement conversion sequencer
`timescale 1ns/1ps
module measurement_conversion_sequencer_bench;
   localparam int US = 2;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rdata_q;
   logic [19:0] adc_sample;
   mcs_pkg::adc_ctl_type adc_ctl_q;
   logic shutdown_q;
   logic done_q;
   logic alert_en_q;
   logic [59:0] vals = 60'h0;
   logic [15:0] tcoef = 16'h0;
   logic [31:0] d;
   logic [31:0] e0;
   int n_conv [3];
   int run_len [3];
   int n0 [3];
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   int seed = 32'h1684;
   int k;

   mcs_sequencer #(.US_CYCLES(US)) u_mcs_sequencer (.clk(clk), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .adc_sample(adc_sample),
      .adc_ctl_q(adc_ctl_q), .shutdown_q(shutdown_q), .done_q(done_q), .alert_en_q(alert_en_q));
   mcs_adc_model u_mcs_adc_model (.clk(clk), .resetn(resetn), .ctl(adc_ctl_q), .vals(vals),
      .sample(adc_sample), .n_conv(n_conv), .run_len(run_len));

   initial begin
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rdata_q;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(v, e);
   endtask
   task automatic wait_done();
      int i;
      i = 0;
      do begin
         @(posedge clk);
         #1 i++;
      end while (done_q !== 1'b1 && i < 20000);
      chk({31'h0, done_q}, 32'h1);
   endtask
   // expected compensated current and power
   function automatic logic [31:0] e_cur();
      logic signed [35:0] p;
      logic [19:0] c;
      p = $signed(vals[19:0]) * $signed(tcoef);
      c = vals[39:20] - p[31:12];
      return {{12{c[19]}}, c};
   endfunction
   function automatic logic [31:0] e_pwr();
      logic signed [39:0] q;
      logic [31:0] i;
      i = e_cur();
      q = $signed(i[19:0]) * $signed(vals[59:40]);
      return q[39:8];
   endfunction
   task automatic results(input logic [1:0] sel);
      if (sel != mcs_pkg::SEL_BUS) begin
         rchk(mcs_pkg::ADDR_CURR, e_cur());
         rchk(mcs_pkg::ADDR_TEMP, {{12{vals[19]}}, vals[19:0]});
      end
      if (sel != mcs_pkg::SEL_CUR) rchk(mcs_pkg::ADDR_VBUS, {12'h0, vals[59:40]});
      if (sel == mcs_pkg::SEL_ALL) rchk(mcs_pkg::ADDR_POWER, e_pwr());
   endtask
   task automatic run(input logic [31:0] setup);
      @(posedge clk);
      vals <= 60'({$random(seed), $random(seed)});
      n0 = n_conv;
      wr(mcs_pkg::ADDR_SETUP, setup);
      wait_done();
   endtask

   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      // reset values and an unmapped place
      #1 chk({31'h0, shutdown_q}, 32'h1);
      rchk(mcs_pkg::ADDR_SETUP, 32'h0);
      rchk(mcs_pkg::ADDR_CTIME, 32'h041c041c);
      rchk(mcs_pkg::ADDR_TTIME, 32'h0000041c);
      rchk(mcs_pkg::ADDR_DIAG, 32'h0);
      wr(8'h3c, 32'hffffffff);
      rchk(8'h3c, 32'h0);
      $display("test reset done");
      tcoef = 16'($random(seed));
      wr(mcs_pkg::ADDR_TCOEF, {16'h0, tcoef});
      wr(mcs_pkg::ADDR_CTIME, 32'h00320032);
      wr(mcs_pkg::ADDR_TTIME, 32'h00000032);
      // triggered runs in every channel selection
      rd(mcs_pkg::ADDR_ENERGY, e0);
      for (k = 1; k < 4; k++) begin
         wr(mcs_pkg::ADDR_DIAG, {30'h0, k[0], 1'b0});
         #1 chk({31'h0, alert_en_q}, {31'h0, k[0]});
         run({30'h0, 2'(k)});
         chk(32'(n_conv[0] - n0[0]), (k == 3) ? 32'h0 : 32'h1);
         chk(32'(n_conv[1] - n0[1]), (k == 3) ? 32'h0 : 32'h1);
         chk(32'(n_conv[2] - n0[2]), (k == 2) ? 32'h0 : 32'h1);
         results(2'(k));
         rchk(mcs_pkg::ADDR_DIAG, {30'h0, k[0], 1'b1});
         chk({31'h0, done_q}, 32'h0);
         chk({31'h0, shutdown_q}, 32'h1);
      end
      rchk(mcs_pkg::ADDR_ENERGY, e0);
      $display("test triggered modes done");
      // clamped and separate conversion times
      wr(mcs_pkg::ADDR_CTIME, 32'h1388000a);
      wr(mcs_pkg::ADDR_TTIME, 32'h00000046);
      run(32'h1);
      for (k = 0; k < 3; k++) begin
         d = (k == 0) ? 70 : (k == 1) ? 50 : 4120;
         chk(32'(run_len[k] >= d * US && run_len[k] <= d * US + 2), 32'h1);
      end
      results(mcs_pkg::SEL_ALL);
      wr(mcs_pkg::ADDR_CTIME, 32'h00320032);
      wr(mcs_pkg::ADDR_TTIME, 32'h00000032);
      $display("test conversion times done");
      // continuous with four-sample averaging
      run(32'h15);
      chk(32'(n_conv[2] - n0[2]), 32'h4);
      chk(32'(n_conv[1] - n0[1]), 32'h4);
      chk({31'h0, shutdown_q}, 32'h0);
      results(mcs_pkg::SEL_ALL);
      rchk(mcs_pkg::ADDR_ENERGY, e_pwr());
      rchk(mcs_pkg::ADDR_CHARGE, e_cur());
      d = e_cur();
      @(posedge clk);
      vals <= ~vals;
      rchk(mcs_pkg::ADDR_CURR, d);
      for (k = 0; k < 20000 && n_conv[2] - n0[2] < 9; k++) @(posedge clk);
      #1 chk({31'h0, done_q}, 32'h1);
      wr(mcs_pkg::ADDR_SETUP, 32'h0);
      #1 chk({31'h0, done_q}, 32'h1);
      rchk(mcs_pkg::ADDR_DIAG, 32'h7);
      chk({31'h0, shutdown_q}, 32'h1);
      $display("test continuous averaging done");
      // abort a continuous run by a delayed trigger
      wr(mcs_pkg::ADDR_SETUP, 32'h5);
      repeat (150) @(posedge clk);
      wr(mcs_pkg::ADDR_TTIME, 32'h00010032);
      wr(mcs_pkg::ADDR_SETUP, 32'h1);
      #1 chk({31'h0, adc_ctl_q.run}, 32'h0);
      k = 0;
      while (adc_ctl_q.run !== 1'b1 && k < 5000) begin
         @(posedge clk);
         #1 k++;
      end
      chk(32'(k >= 2000 * US && k <= 2000 * US + 4), 32'h1);
      wait_done();
      results(mcs_pkg::SEL_ALL);
      $display("test delayed restart done");
      close_out();
   end
endmodule
